// [csi_cfg.svh]
`ifndef CSI_CFG_SVH
`define CSI_CFG_SVH

// timing
`define CSI_CLK_HZ 20000000
`define CSI_DWELL_UNIT_NS 10000

// wheel geometry and scaling
`define CSI_TEETH 24
`define CSI_TOOTH_W 5
`define CSI_DIV 5
`define CSI_NCOIL 4
`define CSI_PERMILLE 1000
`define CSI_PCT_FULL 100

// register byte addresses
`define CSI_A_SYNC 8'h00
`define CSI_A_WIN 8'h04
`define CSI_A_DWELL 8'h08
`define CSI_A_DLIM 8'h0C
`define CSI_A_COIL 8'h10
`define CSI_A_PHM 8'h14
`define CSI_A_PHS 8'h18
`define CSI_A_TRIM 8'h1C
`define CSI_A_SPLIT 8'h20
`define CSI_A_STAT 8'h24
`define CSI_A_PER 8'h28

// reset values
`define CSI_RST_SYNC 32'h00031239
`define CSI_RST_WIN 32'h000000FA
`define CSI_RST_DWELL 32'h6400012C
`define CSI_RST_DLIM 32'h00000C01
`define CSI_RST_COIL 32'h000000FF
`define CSI_RST_PHM 32'h120C0600
`define CSI_RST_ZERO 32'h00000000

// bus responses
`define CSI_RESP_OKAY 2'h0
`define CSI_RESP_SLVERR 2'h2

`endif

// [csi_pkg.sv]
package csi_pkg;
    typedef enum logic [2:0] {
        SYNC_HUNT = 3'h1,
        SYNC_LOCK = 3'h2,
        SYNC_FAULT = 3'h4
    } csi_sync_st_t;

    typedef enum logic [2:0] {
        EV_IDLE = 3'h1,
        EV_CHARGE = 3'h2,
        EV_HOLD = 3'h4
    } csi_ev_t;

    typedef struct packed {
        logic [11:0] rsv;
        logic [3:0] err_limit;
        logic [3:0] sync_teeth;
        logic [3:0] missing;
        logic [7:0] gap_normal_edge_count;
    } csi_sync_t;

    typedef struct packed {
        logic [19:0] rsv;
        logic [11:0] gap_window_percent;
    } csi_win_t;

    typedef struct packed {
        logic [7:0] rpm_pct;
        logic [7:0] rsv;
        logic [15:0] batt_dwell;
    } csi_dwell_t;

    typedef struct packed {
        logic [15:0] rsv;
        logic [7:0] dmax;
        logic [7:0] dmin;
    } csi_dlim_t;

    typedef struct packed {
        logic [15:0] rsv;
        logic [3:0] sec_en;
        logic [3:0] trailing;
        logic [3:0] knock;
        logic [3:0] enable;
    } csi_coil_t;

    typedef struct packed {
        logic [15:0] sec;
        logic [15:0] main;
    } csi_trim_t;

    typedef struct packed {
        logic [7:0] tooth;
        logic [7:0] err;
        logic [3:0] active;
        logic [9:0] rsv;
        logic fault;
        logic synced;
    } csi_stat_t;
endpackage

// [csi_coil.sv]
`include "csi_cfg.svh"

module csi_coil
    import csi_pkg::*;
#(
    parameter int DW = 18
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tooth_stb,
    input wire logic [`CSI_TOOTH_W-1:0] tooth,
    input wire logic fire_ok,
    input wire logic [`CSI_TOOTH_W-1:0] dwell,
    input wire logic [`CSI_TOOTH_W-1:0] phase_main,
    input wire logic [`CSI_TOOTH_W-1:0] phase_sec,
    input wire logic sec_en,
    input wire logic [DW-1:0] dly_main,
    input wire logic [DW-1:0] dly_sec,
    output logic coil_out
);
    logic [1:0][`CSI_TOOTH_W-1:0] ph;
    logic [1:0][DW-1:0] dly;
    logic [1:0] ev_en;
    logic [1:0] chg;

    assign ph = {phase_sec, phase_main};
    assign dly = {dly_sec, dly_main};
    assign ev_en = {sec_en, 1'b1};

    // both events of a pair share one physical output
    for (genvar e = 0; e < 2; e++) begin : g_ev
        csi_ev_t st_ff;
        logic [DW-1:0] cnt_ff;
        logic [5:0] sum;
        logic [`CSI_TOOTH_W-1:0] start;

        // charge begins dwell teeth ahead of the firing tooth
        assign sum = 6'(ph[e]) + 6'(`CSI_TEETH) - 6'(dwell);
        assign start = (sum >= 6'(`CSI_TEETH)) ?
            `CSI_TOOTH_W'(sum - 6'(`CSI_TEETH)) : `CSI_TOOTH_W'(sum);

        always_ff @(posedge aclk) begin
            if (!aresetn || !fire_ok || !ev_en[e]) begin
                st_ff <= EV_IDLE;
                cnt_ff <= '0;
            end else begin
                case (st_ff)
                    EV_IDLE: begin
                        if (tooth_stb && tooth == start) begin
                            st_ff <= EV_CHARGE; // R15
                        end
                    end
                    EV_CHARGE: begin
                        if (tooth_stb && tooth == ph[e]) begin // R14
                            if (dly[e] == '0) begin
                                st_ff <= EV_IDLE;
                            end else begin
                                st_ff <= EV_HOLD;
                                cnt_ff <= dly[e] - DW'(1);
                            end
                        end
                    end
                    EV_HOLD: begin
                        if (cnt_ff == '0) begin
                            st_ff <= EV_IDLE; // R15
                        end else begin
                            cnt_ff <= cnt_ff - DW'(1);
                        end
                    end
                    default: st_ff <= EV_IDLE;
                endcase
            end
        end

        assign chg[e] = st_ff != EV_IDLE;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            coil_out <= 1'b0;
        end else begin
            coil_out <= fire_ok && (|chg); // R8 R10 R15
        end
    end

    gate_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !fire_ok |=> !coil_out) // R8
        else $error("coil driven while firing is blocked");
    spark_late_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(coil_out) && $past(fire_ok)
        |-> $past(|chg, 2) && !$past(|chg)) // R15
        else $error("spark edge without end of charge");
endmodule

// [csi_top.sv]
// Operation
// (R1) every fifth significant crank edge becomes one fuel/spark tooth
// (R2) internal teeth are 30 crank degrees, 24 per engine cycle
// (R3) search for a gap of the configured number of missing edges
// (R4) check the configured normal edge count between gaps, gap edge is zero
// (R5) gap window scaled by a configurable percentage of the tooth period
// (R6) expect the configured number of cam edges between gaps
// (R7) revolution without cam edge counts one sync error, which is normal
// (R8) errors above the limit mean fault; outputs off until resynced
// (R9) four main outputs fire in sequence, six spark teeth apart
// (R10) each main output has a paired secondary event on the same pin
// (R11) output enable change takes effect only at next power-up; the code applies it at the next plain aresetn reset
// (R12) knock correction applies only to outputs with their knock bit set
// (R13) each output selects leading or trailing, leading after reset
// (R14) each output fires at its own tooth offset, setting firing order
// (R15) assert output to charge coil, spark at the falling edge
// (R16) charge time is battery dwell times rpm dwell percentage
// (R17) charge time clamped between minimum and maximum in spark teeth
// (R18) only significant edges advance the tooth counters
// (R19) a divide value of five advances fuel and spark counts by one
// (R20) gap when interval exceeds scaled previous one; counters reset
// (R21) error count clears when a cycle ends with expected counts
`include "csi_cfg.svh"

module csi_top
    import csi_pkg::*;
#(
    parameter int PER_W = 24,
    parameter int ADDR_W = 8,
    parameter int DW = 18
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic por_resetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic crank_in,
    input wire logic cam_in,
    input wire logic [15:0] knock_retard,
    output logic [`CSI_NCOIL-1:0] coil_out,
    output logic sync_ok,
    output logic sync_fault
);
    localparam int NC = `CSI_NCOIL;
    localparam int TW = `CSI_TOOTH_W;
    localparam int UNIT_CYC =
        `CSI_DWELL_UNIT_NS * (`CSI_CLK_HZ / 1000000) / 1000;

    csi_sync_t sync_cfg_ff;
    csi_win_t win_ff;
    csi_dwell_t dwell_ff;
    csi_dlim_t dlim_ff;
    csi_coil_t coil_ff;
    csi_trim_t trim_ff;
    logic [NC-1:0][7:0] phm_ff, phs_ff;
    logic [15:0] split_ff;
    logic [NC-1:0] active_ff;

    logic [ADDR_W-1:0] aw_addr_ff;
    logic aw_v_ff, w_v_ff, wr_do;
    logic [31:0] w_data_ff, rd_word;
    logic [3:0] w_strb_ff;
    logic rd_hit, wr_hit;

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // bus slave: address and data taken in either order
    assign s_axi_awready = !aw_v_ff && !s_axi_bvalid;
    assign s_axi_wready = !w_v_ff && !s_axi_bvalid;
    assign wr_do = aw_v_ff && w_v_ff;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_v_ff <= 1'b0;
            aw_addr_ff <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_v_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
        end else if (wr_do) begin
            aw_v_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_v_ff <= 1'b0;
            w_data_ff <= '0;
            w_strb_ff <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_v_ff <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
        end else if (wr_do) begin
            w_v_ff <= 1'b0;
        end
    end

    always_comb begin
        case (aw_addr_ff)
            `CSI_A_SYNC, `CSI_A_WIN, `CSI_A_DWELL, `CSI_A_DLIM,
            `CSI_A_COIL, `CSI_A_PHM, `CSI_A_PHS, `CSI_A_TRIM,
            `CSI_A_SPLIT: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CSI_RESP_OKAY;
        end else if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `CSI_RESP_OKAY : `CSI_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_cfg_ff <= `CSI_RST_SYNC;
            win_ff <= `CSI_RST_WIN;
            dwell_ff <= `CSI_RST_DWELL;
            dlim_ff <= `CSI_RST_DLIM;
            phm_ff <= `CSI_RST_PHM; // R9 R14
            phs_ff <= `CSI_RST_ZERO;
            trim_ff <= `CSI_RST_ZERO;
            split_ff <= '0;
        end else if (wr_do) begin
            case (aw_addr_ff)
                `CSI_A_SYNC: sync_cfg_ff <= merge(sync_cfg_ff, w_data_ff,
                    w_strb_ff);
                `CSI_A_WIN: win_ff <= merge(win_ff, w_data_ff, w_strb_ff);
                `CSI_A_DWELL: dwell_ff <= merge(dwell_ff, w_data_ff,
                    w_strb_ff);
                `CSI_A_DLIM: dlim_ff <= merge(dlim_ff, w_data_ff, w_strb_ff);
                `CSI_A_PHM: phm_ff <= merge(phm_ff, w_data_ff, w_strb_ff);
                `CSI_A_PHS: phs_ff <= merge(phs_ff, w_data_ff, w_strb_ff);
                `CSI_A_TRIM: trim_ff <= merge(trim_ff, w_data_ff, w_strb_ff);
                `CSI_A_SPLIT: split_ff <= 16'(merge(32'(split_ff), w_data_ff,
                    w_strb_ff));
                default: ;
            endcase
        end
    end

    // survives a plain reset, which copies its enables into active_ff
    always_ff @(posedge aclk) begin
        if (!por_resetn) begin
            coil_ff <= `CSI_RST_COIL; // R13
        end else if (wr_do && aw_addr_ff == `CSI_A_COIL) begin
            coil_ff <= merge(coil_ff, w_data_ff, w_strb_ff);
        end
    end

    always_ff @(posedge aclk) begin
        if (!por_resetn) begin
            active_ff <= NC'(`CSI_RST_COIL);
        end else if (!aresetn) begin
            active_ff <= coil_ff.enable; // R11
        end
    end

    // crank/cam: two-stage synchronisers, third stage for edges
    logic [2:0] crank_sy_ff, cam_sy_ff;
    logic crank_rise, cam_rise, gap, edge_ok, cam_ok, good;
    logic [PER_W-1:0] period_ff, prev_ff, tper_cnt_ff, tper_ff;
    logic [39:0] lhs, rhs;
    logic [15:0] thr;
    logic [7:0] raw_idx_ff;
    logic [2:0] div_ff;
    logic [TW-1:0] tooth_ff, dwell_teeth_ff;
    logic tooth_stb_ff;
    logic [3:0] cam_cnt_ff, err_ff;
    csi_sync_st_t sync_st_ff;
    logic [31:0] charge_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            crank_sy_ff <= '0;
            cam_sy_ff <= '0;
        end else begin
            crank_sy_ff <= {crank_sy_ff[1:0], crank_in};
            cam_sy_ff <= {cam_sy_ff[1:0], cam_in};
        end
    end

    // rising edges are the significant ones
    assign crank_rise = crank_sy_ff[1] && !crank_sy_ff[2]; // R18
    assign cam_rise = cam_sy_ff[1] && !cam_sy_ff[2];

    assign thr = 16'(sync_cfg_ff.missing) * 16'(`CSI_PERMILLE)
        + 16'(win_ff.gap_window_percent); // R3 R5
    assign lhs = 40'(period_ff) * 40'(`CSI_PERMILLE);
    assign rhs = 40'(prev_ff) * 40'(thr);
    assign gap = crank_rise && prev_ff != '0 && lhs > rhs; // R20
    assign edge_ok = raw_idx_ff == sync_cfg_ff.gap_normal_edge_count; // R4
    assign cam_ok = cam_cnt_ff == sync_cfg_ff.sync_teeth; // R6
    assign good = gap && edge_ok && cam_ok;

    // the gap interval never becomes the reference period
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            period_ff <= '0;
            prev_ff <= '0;
        end else if (crank_rise) begin
            period_ff <= PER_W'(1);
            if (!gap) begin
                prev_ff <= period_ff;
            end
        end else if (period_ff != '1) begin
            period_ff <= period_ff + PER_W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cam_cnt_ff <= '0;
        end else if (gap) begin
            cam_cnt_ff <= {3'h0, cam_rise};
        end else if (cam_rise && cam_cnt_ff != '1) begin
            cam_cnt_ff <= cam_cnt_ff + 4'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            err_ff <= '0;
        end else if (gap) begin
            if (good) begin
                err_ff <= '0; // R21
            end else if (sync_st_ff != SYNC_HUNT && err_ff != '1) begin
                err_ff <= err_ff + 4'h1; // R7
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_st_ff <= SYNC_HUNT;
        end else begin
            case (sync_st_ff)
                SYNC_HUNT: if (good) sync_st_ff <= SYNC_LOCK;
                SYNC_LOCK: begin
                    if (gap && !good && err_ff >= sync_cfg_ff.err_limit) begin
                        sync_st_ff <= SYNC_FAULT; // R8
                    end
                end
                SYNC_FAULT: if (good) sync_st_ff <= SYNC_LOCK; // R8
                default: sync_st_ff <= SYNC_HUNT;
            endcase
        end
    end

    // second revolution of the cycle restarts at half the teeth
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            raw_idx_ff <= '0;
            div_ff <= '0;
            tooth_ff <= '0;
            tooth_stb_ff <= 1'b0;
        end else if (gap) begin
            raw_idx_ff <= '0; // R20
            div_ff <= '0;
            tooth_stb_ff <= 1'b1;
            if (!good && cam_cnt_ff == '0 && edge_ok) begin
                tooth_ff <= TW'(`CSI_TEETH / 2);
            end else begin
                tooth_ff <= '0; // R20
            end
        end else if (crank_rise) begin
            if (raw_idx_ff != '1) begin
                raw_idx_ff <= raw_idx_ff + 8'h1;
            end
            if (div_ff == 3'(`CSI_DIV - 1)) begin
                div_ff <= '0; // R1 R19
                tooth_stb_ff <= 1'b1;
                tooth_ff <= (tooth_ff == TW'(`CSI_TEETH - 1)) ? '0 :
                    tooth_ff + TW'(1); // R2
            end else begin
                div_ff <= div_ff + 3'h1;
                tooth_stb_ff <= 1'b0;
            end
        end else begin
            tooth_stb_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tper_cnt_ff <= '0;
            tper_ff <= '0;
        end else if (tooth_stb_ff) begin
            tper_cnt_ff <= PER_W'(1);
            tper_ff <= tper_cnt_ff;
        end else if (tper_cnt_ff != '1) begin
            tper_cnt_ff <= tper_cnt_ff + PER_W'(1);
        end
    end

    // dwell in teeth at the last tooth period, clamped in teeth
    logic [7:0] need, lo, hi, dwl;
    always_comb begin
        need = 8'(`CSI_TEETH - 1);
        for (int k = `CSI_TEETH - 1; k >= 1; k--) begin
            if (32'(k) * 32'(tper_ff) >= charge_ff) begin
                need = 8'(k);
            end
        end
        lo = (dlim_ff.dmin == '0) ? 8'h1 : dlim_ff.dmin;
        hi = (dlim_ff.dmax > 8'(`CSI_TEETH - 1)) ?
            8'(`CSI_TEETH - 1) : dlim_ff.dmax;
        dwl = (need < lo) ? lo : (need > hi) ? hi : need; // R17
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            charge_ff <= '0;
            dwell_teeth_ff <= TW'(1);
        end else begin
            charge_ff <= 32'(dwell_ff.batt_dwell) * 32'(dwell_ff.rpm_pct)
                * 32'(UNIT_CYC) / 32'(`CSI_PCT_FULL); // R16
            dwell_teeth_ff <= TW'(dwl);
        end
    end

    for (genvar i = 0; i < NC; i++) begin : g_coil
        logic [DW-1:0] kn, tr;
        assign kn = coil_ff.knock[i] ? DW'(knock_retard) : '0; // R12
        assign tr = coil_ff.trailing[i] ? DW'(split_ff) : '0; // R13
        csi_coil #(.DW(DW)) u_coil (
            .aclk(aclk),
            .aresetn(aresetn),
            .tooth_stb(tooth_stb_ff),
            .tooth(tooth_ff),
            .fire_ok(sync_st_ff == SYNC_LOCK && active_ff[i]), // R8 R11
            .dwell(dwell_teeth_ff),
            .phase_main(TW'(phm_ff[i])),
            .phase_sec(TW'(phs_ff[i])),
            .sec_en(coil_ff.sec_en[i]), // R10
            .dly_main(DW'(trim_ff.main) + kn + tr),
            .dly_sec(DW'(trim_ff.sec) + kn + tr),
            .coil_out(coil_out[i])
        );
    end

    assign sync_ok = sync_st_ff == SYNC_LOCK;
    assign sync_fault = sync_st_ff == SYNC_FAULT;

    csi_stat_t stat;
    always_comb begin
        stat = '0;
        stat.tooth = 8'(tooth_ff);
        stat.err = 8'(err_ff);
        stat.active = active_ff;
        stat.fault = sync_fault;
        stat.synced = sync_ok;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `CSI_A_SYNC: rd_word = sync_cfg_ff;
            `CSI_A_WIN: rd_word = win_ff;
            `CSI_A_DWELL: rd_word = dwell_ff;
            `CSI_A_DLIM: rd_word = dlim_ff;
            `CSI_A_COIL: rd_word = coil_ff;
            `CSI_A_PHM: rd_word = phm_ff;
            `CSI_A_PHS: rd_word = phs_ff;
            `CSI_A_TRIM: rd_word = trim_ff;
            `CSI_A_SPLIT: rd_word = 32'(split_ff);
            `CSI_A_STAT: rd_word = stat;
            `CSI_A_PER: rd_word = 32'(tper_ff);
            default: begin
                rd_word = '0;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `CSI_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? `CSI_RESP_OKAY : `CSI_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_fifth_edge;
        crank_rise && !gap && div_ff == 3'(`CSI_DIV - 1);
    endsequence
    sequence s_other_edge;
        crank_rise && !gap && div_ff != 3'(`CSI_DIV - 1);
    endsequence

    div_fifth_a: assert property (s_fifth_edge |=> tooth_stb_ff
        && div_ff == '0) // R1
        else $error("fifth edge gave no tooth");
    div_skip_a: assert property (s_other_edge |=> !tooth_stb_ff) // R19
        else $error("tooth on a non-fifth edge");
    tooth_range_a: assert property (tooth_ff < TW'(`CSI_TEETH)) // R2
        else $error("tooth count out of range");
    insig_edge_a: assert property (!crank_rise |=> !tooth_stb_ff) // R18
        else $error("tooth without significant edge");
    gap_reset_a: assert property (gap |=> raw_idx_ff == '0
        && div_ff == '0 && tooth_stb_ff) // R20
        else $error("counters not reset at gap");
    err_count_a: assert property (gap && !good && sync_st_ff != SYNC_HUNT
        && err_ff != '1 |=> err_ff == $past(err_ff) + 4'h1) // R7
        else $error("missed sync error not counted");
    err_clear_a: assert property (good |=> err_ff == '0) // R21
        else $error("error count not cleared on good cycle");
    fault_gate_a: assert property (sync_st_ff != SYNC_LOCK
        |=> coil_out == '0) // R8
        else $error("coil active without sync");
    lock_limit_a: assert property (sync_st_ff == SYNC_LOCK
        |-> err_ff <= sync_cfg_ff.err_limit) // R8
        else $error("locked with errors above limit");
    dwell_clamp_a: assert property (dlim_ff.dmin <= dlim_ff.dmax
        && dlim_ff.dmin != '0 && dlim_ff.dmax < 8'(`CSI_TEETH)
        && $stable(dlim_ff) |=> dwell_teeth_ff >= TW'(dlim_ff.dmin)
        && dwell_teeth_ff <= TW'(dlim_ff.dmax)) // R17
        else $error("dwell teeth outside limits");
endmodule

// [csi_wheel.sv]
module csi_wheel #(
    parameter int HALF = 20
) (
    input wire logic aclk,
    input wire logic run,
    input wire logic cam_en,
    output logic crank_in,
    output logic cam_in
);
    timeunit 1ns;
    timeprecision 1ns;
    int n;
    initial begin
        crank_in = 1'b0;
        cam_in = 1'b0;
        n = 0;
        forever begin
            @(posedge aclk);
            if (run) begin
                repeat (HALF) @(posedge aclk);
                crank_in <= 1'b1;
                cam_in <= cam_en && n == 5;
                repeat (HALF) @(posedge aclk);
                crank_in <= 1'b0;
                cam_in <= 1'b0;
                // two absent teeth stretch the interval to three periods
                if (n % 58 == 57) repeat (4 * HALF) @(posedge aclk);
                n = (n + 1) % 116;
            end
        end
    end
endmodule

// [crank_sync_ignition_scheduler_bench.sv]
`include "csi_cfg.svh"
module crank_sync_ignition_scheduler_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk, aresetn, por_resetn, run, cam_en, mon;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb, coil_out, pc;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, crank_in, cam_in, sync_ok, sync_fault;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [15:0] knock_retard;
    int miscompares, checks, nx, falls;
    csi_top dut (.aclk, .aresetn, .por_resetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .crank_in, .cam_in,
        .knock_retard, .coil_out, .sync_ok, .sync_fault);
    csi_wheel #(.HALF(20)) wheel (.aclk, .run, .cam_en, .crank_in, .cam_in);
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    task automatic end_of_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask
    // one access at a time; handshakes sampled mid-cycle, acted on at edge
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] v);
        logic x, y, z;
        // a fresh edge keeps readies from being reassigned in one step
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        for (int k = 0; k < 50; k++) begin
            @(negedge aclk);
            x = w ? s_axi_awvalid && s_axi_awready
                  : s_axi_arvalid && s_axi_arready;
            y = s_axi_wvalid && s_axi_wready;
            z = w ? s_axi_bvalid : s_axi_rvalid;
            d = s_axi_rdata;
            r = w ? s_axi_bresp : s_axi_rresp;
            @(posedge aclk);
            if (x) begin
                s_axi_awvalid <= 1'b0;
                s_axi_arvalid <= 1'b0;
            end
            if (y) s_axi_wvalid <= 1'b0;
            if (z) begin
                s_axi_bready <= 1'b0;
                s_axi_rready <= 1'b0;
                return;
            end
        end
        miscompares++;
        end_of_test();
    endtask
    task automatic wt(input logic f);
        for (int k = 0; k < 40000; k++) begin
            @(negedge aclk);
            if (f ? sync_fault : sync_ok) return;
        end
        miscompares++;
        end_of_test();
    endtask
    // spark order watch: each falling coil must be the one after the last
    always @(negedge aclk) begin
        for (int i = 0; i < 4; i++) begin
            if (mon && pc[i] === 1'b1 && coil_out[i] === 1'b0) begin
                if (nx >= 0) chk(32'(i), 32'(nx));
                nx = (i + 1) % 4;
                falls++;
            end
        end
        pc = coil_out;
    end
    initial begin
        {aresetn, por_resetn, run, cam_en, mon} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hF;
        knock_retard = 16'h0000;
        nx = -1;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        por_resetn <= 1'b1;
        @(posedge aclk);
        bus(1'b0, `CSI_A_SYNC, '0);
        chk(d, `CSI_RST_SYNC);
        bus(1'b0, `CSI_A_WIN, '0);
        chk(d, `CSI_RST_WIN);
        bus(1'b0, `CSI_A_COIL, '0);
        chk(d, `CSI_RST_COIL);
        bus(1'b0, `CSI_A_PHM, '0);
        chk(d, `CSI_RST_PHM);
        bus(1'b0, 8'h40, '0);
        chk(d, 32'h00000000);
        chk(32'(r), 32'(`CSI_RESP_SLVERR));
        bus(1'b1, `CSI_A_STAT, 32'hFFFFFFFF);
        chk(32'(r), 32'(`CSI_RESP_SLVERR));
        $display("test registers done");
        run <= 1'b1;
        cam_en <= 1'b1;
        wt(1'b0);
        chk(32'(sync_fault), 32'h0);
        mon <= 1'b1;
        repeat (12000) @(posedge aclk);
        mon = 0;
        chk(32'(falls >= 8), 32'h1);
        $display("test firing done");
        cam_en <= 1'b0;
        wt(1'b1);
        // coil drivers follow the sync state one cycle later
        @(negedge aclk);
        chk({28'(sync_ok), coil_out}, 32'h0);
        cam_en <= 1'b1;
        wt(1'b0);
        bus(1'b0, `CSI_A_STAT, '0);
        chk(32'(d[23:16]), 32'h0);
        $display("test fault done");
        end_of_test();
    end
endmodule
